//--- rtl/grf_defines.vh
// shared constants of the graphics replenishment framer
`ifndef GRF_DEFINES_VH
`define GRF_DEFINES_VH
// sync byte values, bit value 0 and 1
`define GRF_SYNC0 8'hF3
`define GRF_SYNC1 8'hFC
// replenishment stride and sequence
`define GRF_STRIDE 11'h013
`define GRF_SEQ_LEN 6'h13
`define GRF_SEQ_LAST 6'h25
`define GRF_SYNC_LAST 3'h7
`define GRF_ADDR_MAX 7'h12
// picture geometry
`define GRF_M1_W 10'h27F
`define GRF_M2_W 10'h168
`define GRF_LAST_LINE 9'h11F
`define GRF_F1_LINE 10'h017
`define GRF_F2_LINE 10'h150
// amplitude limits
`define GRF_Y6_MAX 6'h3B
`define GRF_C6_SIGN 6'h20
`define GRF_Y8_MIN 8'h10
`define GRF_Y8_MAX 8'hEB
`define GRF_C8_MIN 8'h10
`define GRF_C8_MAX 8'hF0
// buffer suspension, level counted in bits
`define GRF_BUF_LIM 18'h27100
`define GRF_SUSP_FIELDS 2'h2
// register map, byte offsets on the low address bits
`define GRF_REG_CTRL 4'h0
`define GRF_REG_STAT 4'h4
`define GRF_REG_FIELD 4'h8
`define GRF_CTRL_RUN 0
`define GRF_CTRL_MODE2 1
`define GRF_CTRL_CONT 2
`define GRF_STAT_DONE 2
`define GRF_RESP_OKAY 2'h0
`define GRF_RESP_SLVERR 2'h2
`endif

//--- rtl/grf_serializer.v
// byte to bit serializer aligned to channel time slots
`timescale 1ns/1ps
module grf_serializer
(
    input wire clk,
    input wire rst,
    input wire slot_tick,
    input wire slot_first,
    input wire [7:0] byte_data,
    input wire byte_valid,
    output wire byte_ready,
    output reg tx_bit_q,
    output reg tx_en_q,
    output reg tx_start_q
);
    reg [7:0] sh_q; // bits still to go, msb leading
    reg [2:0] left_q; // bits remaining after the current one
    reg busy_q; // a byte is in flight

    // a new byte starts only on the first bit of a slot, so octets never straddle slots
    assign byte_ready = slot_tick & slot_first & ~(busy_q & (left_q != 3'h0));

    // shift msb first, one bit per slot tick
    always @(posedge clk)
    begin
        if (rst)
        begin
            sh_q <= 8'h00;
            left_q <= 3'h0;
            busy_q <= 1'b0;
            tx_bit_q <= 1'b0;
            tx_en_q <= 1'b0;
            tx_start_q <= 1'b0;
        end
        else if (slot_tick)
        begin
            tx_start_q <= 1'b0;
            if (byte_ready & byte_valid)
            begin
                // load: first bit out now, R11 R16
                tx_bit_q <= byte_data[7];
                tx_en_q <= 1'b1;
                tx_start_q <= 1'b1;
                sh_q <= {byte_data[6:0], 1'b0};
                left_q <= 3'h7;
                busy_q <= 1'b1;
            end
            else if (busy_q & (left_q != 3'h0))
            begin
                tx_bit_q <= sh_q[7];
                sh_q <= {sh_q[6:0], 1'b0};
                left_q <= left_q - 3'h1;
            end
            else
            begin
                // empty slot bit: nothing to send
                busy_q <= 1'b0;
                tx_en_q <= 1'b0;
                tx_bit_q <= 1'b0;
            end
        end
    end
endmodule

//--- rtl/grf_framer.v
// still-picture replenishment framer and deframer with axi4-lite control
//
// Local design decisions: the placing of the registers and the AXI4-Lite register port.
`timescale 1ns/1ps
`include "grf_defines.vh"
// Overview of operation
// R01: mode 1 sends every 19th element, wrapping lines
// R02: eight sync bytes; picture never uses them
// R03: first seven sync bytes carry start address
// R04: eighth sync byte gives field parity
// R05: start addresses follow 38-field recommended order
// R06: field length follows start address, 9686/9685
// R07: luma six high bits, chroma pair low
// R08: chroma pairs ride three consecutive sent words
// R09: no chroma on picture's first line
// R10: buffer over 160 kbits suspends two fields
// R11: output octets aligned to time slots
// R12: decoder addresses 639 by 576 byte store
// R13: mode 2 sets of Cb Y Cr Y
// R14: mode 2 sends every 19th set
// R15: mode 2 sync uses same coding
// R16: set words serialized in order, msb first
// R17: clamp luma 16-235, chroma 225 levels
// R18: mode 2 decoder places sets in store
// R19: continuous mode keeps resending, live frozen
// R20: chroma co-sited with even luma samples
// R21: counter starts at address, steps 19, stops
module grf_framer
#(
    parameter ADDR_W = 4
)
(
    input wire clk,
    input wire rst,
    input wire [ADDR_W-1:0] s_axi_awaddr,
    input wire s_axi_awvalid,
    output reg s_axi_awready,
    input wire [31:0] s_axi_wdata,
    input wire [3:0] s_axi_wstrb,
    input wire s_axi_wvalid,
    output reg s_axi_wready,
    output reg [1:0] s_axi_bresp,
    output reg s_axi_bvalid,
    input wire s_axi_bready,
    input wire [ADDR_W-1:0] s_axi_araddr,
    input wire s_axi_arvalid,
    output reg s_axi_arready,
    output reg [31:0] s_axi_rdata,
    output reg [1:0] s_axi_rresp,
    output reg s_axi_rvalid,
    input wire s_axi_rready,
    output reg pix_req_q,
    output reg [9:0] pix_line_q,
    output reg [9:0] pix_col_q,
    input wire pix_valid,
    input wire [31:0] pix_data,
    input wire field_tick,
    input wire [17:0] buf_level,
    input wire slot_tick,
    input wire slot_first,
    output wire tx_bit_q,
    output wire tx_en_q,
    output wire tx_start_q,
    output reg live_freeze_q,
    input wire rx_valid,
    input wire [7:0] rx_byte,
    output reg st_we_q,
    output reg [9:0] st_row_q,
    output reg [9:0] st_col_q,
    output reg [1:0] st_word_q,
    output reg [7:0] st_data_q
);
    localparam S_IDLE = 3'h0;
    localparam S_SYNC = 3'h1;
    localparam S_REQ = 3'h2;
    localparam S_WAIT = 3'h3;
    localparam S_EMIT = 3'h4;
    localparam S_FEND = 3'h5;
    localparam S_SUSP = 3'h6;
    localparam D_HUNT = 1'b0;
    localparam D_DATA = 1'b1;

    // start address table of the recommended replenishment order
    function [4:0] seq_addr;
        input [5:0] i;
        begin
            case (i)
                6'h00: seq_addr = 5'h01;
                6'h01: seq_addr = 5'h0D;
                6'h02: seq_addr = 5'h06;
                6'h03: seq_addr = 5'h12;
                6'h04: seq_addr = 5'h03;
                6'h05: seq_addr = 5'h0A;
                6'h06: seq_addr = 5'h0F;
                6'h07: seq_addr = 5'h04;
                6'h08: seq_addr = 5'h00;
                6'h09: seq_addr = 5'h08;
                6'h0A: seq_addr = 5'h0C;
                6'h0B: seq_addr = 5'h05;
                6'h0C: seq_addr = 5'h0E;
                6'h0D: seq_addr = 5'h09;
                6'h0E: seq_addr = 5'h11;
                6'h0F: seq_addr = 5'h02;
                6'h10: seq_addr = 5'h0B;
                6'h11: seq_addr = 5'h07;
                default: seq_addr = 5'h10;
            endcase
        end
    endfunction

    // advance a position by the stride; msb flags the wrap into the next line
    function [10:0] grf_step;
        input [9:0] col;
        input [9:0] w;
        reg [10:0] s;
        begin
            s = {1'b0, col} + `GRF_STRIDE;
            if (s >= {1'b0, w})
                grf_step = {1'b1, s[9:0] - w};
            else
                grf_step = {1'b0, s[9:0]};
        end
    endfunction

    // hard limiter for eight-bit codes
    function [7:0] clamp8;
        input [7:0] v;
        input [7:0] lo;
        input [7:0] hi;
        begin
            if (v < lo)
                clamp8 = lo;
            else if (v > hi)
                clamp8 = hi;
            else
                clamp8 = v;
        end
    endfunction

    reg [2:0] ctrl_q; // run, mode2, continuous
    reg done_q; // sticky: single shot finished
    reg [2:0] st_q; // encoder state
    reg [5:0] fidx_q; // position in the 38-field cycle
    reg [2:0] sync_n_q; // sync byte number
    reg [8:0] line_q; // line within field
    reg [9:0] col_q; // element or set along the line
    reg [1:0] word_q; // word within set, mode 2 only
    reg [1:0] pair_q; // chroma pair of the next mode-1 word
    reg [31:0] pix_q; // captured sample data
    reg [1:0] susp_q; // fields still to skip
    reg ob_valid_q; // byte waiting for the serializer
    reg [7:0] ob_data_q;
    reg dst_q; // decoder state
    reg [2:0] dsc_q; // sync bytes seen in a row
    reg [6:0] dsh_q; // received address bits
    reg [6:0] daddr_q; // last received start address
    reg dfirst_q; // received parity, 1 = first field
    reg [8:0] dline_q;
    reg [9:0] dcol_q;
    reg [1:0] dword_q;

    wire mode2 = ctrl_q[`GRF_CTRL_MODE2];
    wire [9:0] width = mode2 ? `GRF_M2_W : `GRF_M1_W;
    wire half = fidx_q >= `GRF_SEQ_LEN;
    wire [5:0] seq_i = half ? fidx_q - `GRF_SEQ_LEN : fidx_q;
    wire [4:0] start = seq_addr(seq_i); // R05
    wire first_fld = seq_i[0] ^ half; // R05
    wire [6:0] sync_addr = {2'b00, start};
    wire [10:0] enc_nx = grf_step(col_q, width);
    wire enc_end = enc_nx[10] & (line_q == `GRF_LAST_LINE);
    wire ob_ready;
    wire ob_take = ob_valid_q & ob_ready;
    wire ob_free = ~ob_valid_q | ob_take;
    wire over = buf_level > `GRF_BUF_LIM;
    wire [5:0] c6 = pix_q[11:6] ^ `GRF_C6_SIGN;
    wire [5:0] y6 = (pix_q[5:0] > `GRF_Y6_MAX) ? `GRF_Y6_MAX : pix_q[5:0];
    reg [1:0] cpair;
    reg [7:0] enc_byte;

    // picture byte for the current word
    always @*
    begin
        cpair = 2'b00;
        enc_byte = 8'h00;
        case (pair_q)
            2'h0: cpair = c6[5:4]; // R07 R08
            2'h1: cpair = c6[3:2];
            default: cpair = c6[1:0];
        endcase
        if (line_q == 9'h000)
            cpair = 2'b00; // R09
        if (!mode2)
            enc_byte = {y6, cpair}; // R02 R07
        else
        begin
            // R13 R16 R20: Cb n, Y n, Cr n, Y n+1
            case (word_q)
                2'h0: enc_byte = clamp8(pix_q[7:0], `GRF_C8_MIN, `GRF_C8_MAX); // R17
                2'h1: enc_byte = clamp8(pix_q[15:8], `GRF_Y8_MIN, `GRF_Y8_MAX); // R17
                2'h2: enc_byte = clamp8(pix_q[23:16], `GRF_C8_MIN, `GRF_C8_MAX);
                default: enc_byte = clamp8(pix_q[31:24], `GRF_Y8_MIN, `GRF_Y8_MAX); // R02
            endcase
        end
    end

    // encoder: sync, fetch, emit, field end, suspension
    always @(posedge clk)
    begin
        if (rst)
        begin
            st_q <= S_IDLE;
            fidx_q <= 6'h00;
            sync_n_q <= 3'h0;
            line_q <= 9'h000;
            col_q <= 10'h000;
            word_q <= 2'h0;
            pair_q <= 2'h0;
            pix_q <= 32'h0000_0000;
            susp_q <= 2'h0;
            ob_valid_q <= 1'b0;
            ob_data_q <= 8'h00;
            pix_req_q <= 1'b0;
            pix_line_q <= 10'h000;
            pix_col_q <= 10'h000;
            live_freeze_q <= 1'b0;
        end
        else
        begin
            if (ob_take)
                ob_valid_q <= 1'b0;
            case (st_q)
                S_IDLE:
                begin
                    live_freeze_q <= 1'b0;
                    fidx_q <= 6'h00;
                    if (ctrl_q[`GRF_CTRL_RUN])
                    begin
                        live_freeze_q <= 1'b1; // R19
                        sync_n_q <= 3'h0;
                        st_q <= S_SYNC;
                    end
                end
                S_SYNC:
                begin
                    if (ob_free)
                    begin
                        ob_valid_q <= 1'b1;
                        if (sync_n_q != `GRF_SYNC_LAST)
                            // msb of the address first, R03 R15
                            ob_data_q <= sync_addr[3'h6 - sync_n_q] ? `GRF_SYNC1 : `GRF_SYNC0;
                        else
                            ob_data_q <= first_fld ? `GRF_SYNC1 : `GRF_SYNC0; // R04
                        sync_n_q <= sync_n_q + 3'h1;
                        if (sync_n_q == `GRF_SYNC_LAST)
                        begin
                            line_q <= 9'h000; // R21
                            col_q <= {5'h00, start}; // R21
                            pair_q <= 2'h0;
                            st_q <= S_REQ;
                        end
                    end
                end
                S_REQ:
                begin
                    pix_req_q <= 1'b1;
                    pix_line_q <= (first_fld ? `GRF_F1_LINE : `GRF_F2_LINE) + {1'b0, line_q}; // R04
                    pix_col_q <= col_q;
                    word_q <= 2'h0;
                    st_q <= S_WAIT;
                end
                S_WAIT:
                begin
                    if (pix_valid)
                    begin
                        pix_req_q <= 1'b0;
                        pix_q <= pix_data;
                        st_q <= S_EMIT;
                    end
                end
                S_EMIT:
                begin
                    if (ob_free)
                    begin
                        ob_valid_q <= 1'b1;
                        ob_data_q <= enc_byte;
                        word_q <= word_q + 2'h1;
                        if (!mode2 || word_q == 2'h3)
                        begin
                            // R01 R14 R21: stride runs across line ends
                            col_q <= enc_nx[9:0];
                            line_q <= line_q + {8'h00, enc_nx[10]};
                            pair_q <= (enc_nx[10] || pair_q == 2'h2) ? 2'h0 : pair_q + 2'h1; // R08
                            st_q <= enc_end ? S_FEND : S_REQ; // R06 R21
                        end
                    end
                end
                S_FEND:
                begin
                    fidx_q <= (fidx_q == `GRF_SEQ_LAST) ? 6'h00 : fidx_q + 6'h01;
                    sync_n_q <= 3'h0;
                    if (!ctrl_q[`GRF_CTRL_RUN] ||
                        (!ctrl_q[`GRF_CTRL_CONT] && fidx_q == `GRF_SEQ_LAST))
                        st_q <= S_IDLE; // R19
                    else if (over)
                    begin
                        susp_q <= `GRF_SUSP_FIELDS; // R10
                        st_q <= S_SUSP;
                    end
                    else
                        st_q <= S_SYNC;
                end
                S_SUSP:
                begin
                    if (field_tick)
                    begin
                        if (susp_q != 2'h1)
                            susp_q <= susp_q - 2'h1;
                        else if (over)
                            susp_q <= `GRF_SUSP_FIELDS; // R10
                        else
                            st_q <= S_SYNC;
                    end
                end
                default: st_q <= S_IDLE;
            endcase
        end
    end

    wire rx_sync = (rx_byte == `GRF_SYNC0) || (rx_byte == `GRF_SYNC1);
    wire rx_bit = rx_byte == `GRF_SYNC1;
    wire [10:0] dec_nx = grf_step(dcol_q, width);

    // decoder: find eight sync bytes, then address each byte into the store
    always @(posedge clk)
    begin
        if (rst)
        begin
            dst_q <= D_HUNT;
            dsc_q <= 3'h0;
            dsh_q <= 7'h00;
            daddr_q <= 7'h00;
            dfirst_q <= 1'b0;
            dline_q <= 9'h000;
            dcol_q <= 10'h000;
            dword_q <= 2'h0;
            st_we_q <= 1'b0;
            st_row_q <= 10'h000;
            st_col_q <= 10'h000;
            st_word_q <= 2'h0;
            st_data_q <= 8'h00;
        end
        else
        begin
            st_we_q <= 1'b0;
            if (rx_valid && rx_sync)
            begin
                // any sync byte, even mid-field, restarts the hunt for a code
                dst_q <= D_HUNT;
                dsh_q <= {dsh_q[5:0], rx_bit}; // R03 R15
                dsc_q <= dsc_q + 3'h1;
                if (dsc_q == `GRF_SYNC_LAST)
                begin
                    dsc_q <= 3'h0;
                    dfirst_q <= rx_bit; // R04
                    daddr_q <= dsh_q;
                    dline_q <= 9'h000;
                    dcol_q <= {3'h0, dsh_q};
                    dword_q <= 2'h0;
                    // out-of-range address: field is discarded
                    if (dsh_q <= `GRF_ADDR_MAX)
                        dst_q <= D_DATA;
                end
            end
            else if (rx_valid)
            begin
                dsc_q <= 3'h0;
                if (dst_q == D_DATA)
                begin
                    // row interleaves the two fields into one frame, R12 R18
                    st_we_q <= 1'b1;
                    st_row_q <= {dline_q, ~dfirst_q};
                    st_col_q <= dcol_q;
                    st_word_q <= mode2 ? dword_q : 2'h0;
                    st_data_q <= rx_byte;
                    dword_q <= dword_q + 2'h1;
                    if (!mode2 || dword_q == 2'h3)
                    begin
                        dcol_q <= dec_nx[9:0];
                        dline_q <= dline_q + {8'h00, dec_nx[10]};
                        if (dec_nx[10] && dline_q == `GRF_LAST_LINE)
                            dst_q <= D_HUNT; // R06
                    end
                end
            end
        end
    end

    // octets leave only on slot starts, R11
    grf_serializer grf_serializer_inst
    (
        .clk(clk),
        .rst(rst),
        .slot_tick(slot_tick),
        .slot_first(slot_first),
        .byte_data(ob_data_q),
        .byte_valid(ob_valid_q),
        .byte_ready(ob_ready),
        .tx_bit_q(tx_bit_q),
        .tx_en_q(tx_en_q),
        .tx_start_q(tx_start_q)
    );

    wire wr_go = s_axi_awvalid & s_axi_wvalid & ~s_axi_bvalid & ~s_axi_awready;
    wire wr_ctrl = wr_go && s_axi_awaddr[3:0] == `GRF_REG_CTRL && s_axi_wstrb[0];
    wire wr_stat = wr_go && s_axi_awaddr[3:0] == `GRF_REG_STAT && s_axi_wstrb[0];
    wire fin = (st_q == S_FEND) && !ctrl_q[`GRF_CTRL_CONT] && fidx_q == `GRF_SEQ_LAST;

    // write channel: take address and data together, answer one cycle later
    always @(posedge clk)
    begin
        if (rst)
        begin
            s_axi_awready <= 1'b0;
            s_axi_wready <= 1'b0;
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= `GRF_RESP_OKAY;
            ctrl_q <= 3'h0;
            done_q <= 1'b0;
        end
        else
        begin
            s_axi_awready <= wr_go;
            s_axi_wready <= wr_go;
            if (wr_go)
            begin
                s_axi_bvalid <= 1'b1;
                s_axi_bresp <= (s_axi_awaddr[3:0] == `GRF_REG_CTRL ||
                    s_axi_awaddr[3:0] == `GRF_REG_STAT) ? `GRF_RESP_OKAY : `GRF_RESP_SLVERR;
            end
            else if (s_axi_bready)
                s_axi_bvalid <= 1'b0;
            if (wr_ctrl)
                ctrl_q <= s_axi_wdata[2:0];
            else if (fin)
                ctrl_q[`GRF_CTRL_RUN] <= 1'b0; // single shot ends by itself
            // hardware set wins over a write-one clear
            if (fin)
                done_q <= 1'b1;
            else if (wr_stat && s_axi_wdata[`GRF_STAT_DONE])
                done_q <= 1'b0;
        end
    end

    // read channel: one outstanding read, data one cycle after address
    always @(posedge clk)
    begin
        if (rst)
        begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid <= 1'b0;
            s_axi_rdata <= 32'h0000_0000;
            s_axi_rresp <= `GRF_RESP_OKAY;
        end
        else
        begin
            s_axi_arready <= s_axi_arvalid & ~s_axi_rvalid & ~s_axi_arready;
            if (s_axi_arvalid & ~s_axi_rvalid & ~s_axi_arready)
            begin
                s_axi_rvalid <= 1'b1;
                s_axi_rresp <= `GRF_RESP_OKAY;
                case (s_axi_araddr[3:0])
                    `GRF_REG_CTRL: s_axi_rdata <= {29'h0, ctrl_q};
                    `GRF_REG_STAT: s_axi_rdata <= {28'h0, dst_q, done_q, st_q == S_SUSP, live_freeze_q};
                    `GRF_REG_FIELD: s_axi_rdata <= {10'h0, dfirst_q, daddr_q[4:0], 2'h0, fidx_q, 3'h0, start};
                    default:
                    begin
                        s_axi_rdata <= 32'h0000_0000;
                        s_axi_rresp <= `GRF_RESP_SLVERR;
                    end
                endcase
            end
            else if (s_axi_rready)
                s_axi_rvalid <= 1'b0;
        end
    end
endmodule

//--- tb/grf_framer_monitor.sv
// port checker for the graphics framer
`timescale 1ns/1ps
module grf_framer_monitor
(
    input wire clk,
    input wire rst,
    input wire s_axi_awvalid,
    input wire s_axi_wvalid,
    input wire s_axi_awready,
    input wire s_axi_wready,
    input wire s_axi_bvalid,
    input wire s_axi_bready,
    input wire s_axi_arvalid,
    input wire s_axi_arready,
    input wire s_axi_rvalid,
    input wire s_axi_rready,
    input wire slot_tick,
    input wire slot_first,
    input wire tx_bit_q,
    input wire tx_en_q,
    input wire tx_start_q,
    input wire pix_req_q,
    input wire pix_valid,
    input wire [9:0] pix_col_q
);
    default clocking @(posedge clk); endclocking
    default disable iff (rst);
    // write taken one cycle after both halves are offered
    write_take_a: assert property (s_axi_awvalid && s_axi_wvalid && !s_axi_bvalid && !s_axi_awready
        |=> s_axi_awready && s_axi_wready && s_axi_bvalid) else $error("write not taken");
    bresp_hold_a: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid) else $error("bvalid dropped");
    read_take_a: assert property (s_axi_arvalid && !s_axi_rvalid && !s_axi_arready
        |=> s_axi_arready && s_axi_rvalid) else $error("read not taken");
    read_hold_a: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid) else $error("rvalid dropped");
    // serial outputs move only on slot ticks, octets open on slot starts
    tx_slot_a: assert property (!slot_tick |=> $stable({tx_bit_q, tx_en_q, tx_start_q})) else $error("tx off tick");
    tx_octet_a: assert property (slot_tick && !slot_first |=> !tx_start_q) else $error("octet misaligned");
    pix_hold_a: assert property (pix_req_q && !pix_valid |=> pix_req_q && $stable(pix_col_q)) else $error("req moved");
    pix_range_a: assert property (pix_req_q |-> pix_col_q < 10'h27F) else $error("column out of line");
endmodule

//--- tb/grf_partner.sv
// far end model: slot timing, octet assembly, loop back to the receiver
`timescale 1ns/1ps
module grf_partner
(
    input wire clk,
    input wire rst,
    input wire tx_bit_q,
    input wire tx_en_q,
    input wire tx_start_q,
    output logic slot_tick,
    output logic slot_first,
    output logic rx_valid,
    output logic [7:0] rx_byte
);
    logic [3:0] ph_q; // two clocks per bit, eight bits per slot
    logic tk_q; // bit is on the line in this cycle
    logic [7:0] sh_q;
    logic [3:0] nb_q;
    assign slot_tick = ph_q[0];
    assign slot_first = ph_q[3:1] == 3'h0;
    // bits counted from the octet start mark; a lost start mark shows as a missing octet
    always @(posedge clk)
    begin
        ph_q <= rst ? 4'h0 : ph_q + 4'h1;
        tk_q <= slot_tick && !rst;
        sh_q <= tk_q ? {sh_q[6:0], tx_bit_q} : sh_q; // one shift per slot bit
        rx_byte <= {sh_q[6:0], tx_bit_q};
        rx_valid <= !rst && tk_q && tx_en_q && !tx_start_q && nb_q == 4'h7;
        if (tk_q && tx_en_q)
            nb_q <= tx_start_q ? 4'h1 : nb_q + 4'h1;
    end
endmodule

//--- tb/grf_framer_tb.sv
// self-checking bench for the graphics replenishment framer
`timescale 1ns/1ps
module grf_framer_tb;
    logic clk = 1'b0;
    logic rst = 1'b1;
    logic [3:0] s_axi_awaddr = 4'h0, s_axi_araddr = 4'h0, s_axi_wstrb = 4'hF;
    logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata, pix_data = 32'h0;
    logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0, s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
    logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid, live_freeze_q, st_we_q;
    logic pix_req_q, pix_valid = 1'b0, field_tick = 1'b0, slot_tick, slot_first, tx_bit_q, tx_en_q, tx_start_q;
    logic [1:0] s_axi_bresp, s_axi_rresp, st_word_q;
    logic [9:0] pix_line_q, pix_col_q, st_row_q, st_col_q;
    logic [17:0] buf_level = 18'h00100; // well under the suspension level
    logic [7:0] rx_byte, st_data_q;
    logic rx_valid, m2 = 1'b0;
    int err_count = 0, checks_done = 0, seed = 49, cyc = 0, np = 0, nk = 0, nb = 0;
    logic [39:0] exp_r[$], exp_b[$], exp_tx[$], exp_st[$]; // expected results, oldest first
    grf_framer grf_framer_inst (.*);
    grf_partner grf_partner_inst (.*);
    initial forever #20 clk = ~clk;
    task automatic cmp(input string n, input logic [39:0] e, input logic [39:0] g);
        checks_done++;
        if (g !== e)
        begin
            err_count++;
            $display("mismatch %s expected %h seen %h", n, e, g);
        end
    endtask
    task automatic close_out;
        $display("checks %0d errors %0d", checks_done, err_count);
        if (err_count == 0 && checks_done > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask
    function automatic logic [7:0] lim(input logic [7:0] v, input logic y);
        logic [7:0] hi;
        hi = y ? 8'hEB : 8'hF0;
        return v < 8'h10 ? 8'h10 : (v > hi ? hi : v);
    endfunction
    // bus write: both halves offered together, held until taken
    task automatic axw(input logic [3:0] a, input logic [31:0] d, input logic [1:0] r);
        @(posedge clk);
        exp_b.push_back({38'h0, r});
        s_axi_awaddr <= a;
        s_axi_wdata <= d;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        do @(posedge clk); while (!s_axi_awready);
        s_axi_awvalid <= 1'b0;
        s_axi_wvalid <= 1'b0;
        while (!s_axi_bvalid) @(posedge clk);
        s_axi_bready <= 1'b0;
    endtask
    task automatic axr(input logic [3:0] a, input logic [33:0] e);
        @(posedge clk);
        exp_r.push_back({6'h0, e});
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        do @(posedge clk); while (!s_axi_arready);
        s_axi_arvalid <= 1'b0;
        while (!s_axi_rvalid) @(posedge clk);
        s_axi_rready <= 1'b0;
    endtask
    // reset for three clocks, then forget what the last run left behind
    task automatic run_reset(input logic mode);
        rst <= 1'b1;
        repeat (3) @(posedge clk);
        exp_tx.delete();
        exp_st.delete();
        {np, nk, nb} = 0;
        m2 = mode;
        rst <= 1'b0;
    endtask
    // pixel source answers each request one cycle later with random data
    always @(posedge clk)
    begin
        logic [31:0] r;
        if (pix_req_q && !pix_valid && !rst)
        begin
            r = $random(seed);
            pix_valid <= 1'b1;
            pix_data <= r;
            cmp("column", 40'(1 + 19 * np), {30'h0, pix_col_q});
            cmp("line", 40'h150, {30'h0, pix_line_q});
            cmp("freeze", 40'h1, {39'h0, live_freeze_q});
            np++;
            for (int i = 0; i < 4; i++)
                if (m2 || i == 0)
                    exp_tx.push_back(m2 ? lim(r[i*8 +: 8], i[0]) : (r[5:0] > 6'h3B ? 8'hEC : {r[5:0], 2'h0}));
        end
        else
            pix_valid <= 1'b0;
    end
    // result watcher: each result takes the oldest note of its kind
    always @(posedge clk)
    begin
        cyc++;
        if (s_axi_rvalid && s_axi_rready && exp_r.size() > 0)
            cmp("rdata", exp_r.pop_front(), {6'h0, s_axi_rresp, s_axi_rdata});
        if (s_axi_bvalid && s_axi_bready && exp_b.size() > 0)
            cmp("bresp", exp_b.pop_front(), {38'h0, s_axi_bresp});
        if (rx_valid && exp_tx.size() > 0)
        begin
            cmp("tx_byte", exp_tx.pop_front(), {32'h0, rx_byte});
            nb++;
        end
        if (rx_valid && rx_byte !== 8'hF3 && rx_byte !== 8'hFC)
        begin
            exp_st.push_back({10'h001, 10'(m2 ? 1 + 19 * (nk / 4) : 1 + 19 * nk), 2'(m2 ? nk % 4 : 0), rx_byte});
            nk++;
        end
        if (st_we_q && exp_st.size() > 0)
            cmp("store", exp_st.pop_front(), {10'h0, st_row_q, st_col_q, st_word_q, st_data_q});
        if (cyc > 20000)
        begin
            err_count++;
            close_out;
        end
    end
    initial
    begin
        run_reset(1'b0);
        axr(4'h0, 34'h0);
        axr(4'hC, {2'h2, 32'h0});
        axw(4'hC, 32'h1, 2'h2);
        axr(4'h0, 34'h0);
        // mode 1 then mode 2: first field has address 1, second field parity
        for (int m = 0; m < 2; m++)
        begin
            run_reset(m[0]);
            for (int i = 0; i < 8; i++)
                exp_tx.push_back(i == 6 ? 8'hFC : 8'hF3);
            axw(4'h0, {30'h0, m[0], 1'b1}, 2'h0);
            axr(4'h0, {32'h0, m[0], 1'b1});
            wait (nb >= 24);
        end
        close_out;
    end
endmodule
bind grf_framer grf_framer_monitor grf_framer_monitor_inst (.*);
